/* core/burst_addr_gen.sv */
// burst counter: two-bit linear or interleaved address sequence
`timescale 1ns/1ns
`default_nettype none
module burst_addr_gen
   import sram_port_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic load,
   input wire logic advance,
   input wire logic [1:0] seed,
   input wire logic linear_mode,
   output logic [1:0] burst_addr
);
   logic [1:0] base_reg;
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic [1:0] addr_lin;
   logic [1:0] addr_ilv;

   // linear adds the count, interleaved xors it
   assign addr_lin = 2'(base_reg + count_reg);
   assign addr_ilv = base_reg ^ count_reg;
   assign burst_addr = linear_mode ? addr_lin : addr_ilv;
   assign count_next = 2'(count_reg + 2'h1);

   // seed on load, step on advance, wraps after four
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         base_reg <= BURST_RESET;
         count_reg <= BURST_RESET;
      end else if (load) begin
         base_reg <= seed;
         count_reg <= BURST_RESET;
      end else if (advance) begin
         count_reg <= count_next;
      end
   end
endmodule : burst_addr_gen
`default_nettype wire

/* core/sram_port_pkg.sv */
// package: widths, reset values, burst orders and sleep timing for the port
package sram_port_pkg;
   localparam int DATA_BYTES = 4;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 10;
   localparam int SLEEP_SYNC_STAGES = 2;
   localparam logic [1:0] BURST_RESET = 2'h0;
   localparam logic MODE_LINEAR = 1'b0;

   typedef enum logic [1:0] {
      ST_DESEL = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b11,
      ST_SLEEP = 2'b10
   } port_state_t;

   // synchronous controls sampled together at each qualified edge
   typedef struct packed {
      logic chip_sel_n_a;
      logic chip_sel_b;
      logic chip_sel_n_c;
      logic write_sel_n;
      logic advance_or_load;
      logic [DATA_BYTES-1:0] byte_write_n;
   } port_ctrl_t;
endpackage : sram_port_pkg

/* core/sync_sram_port_control.sv */
// top: synchronous flow-through burst sram port with storage and pin control
`timescale 1ns/1ns
`default_nettype none
module sync_sram_port_control
   import sram_port_pkg::*;
#(
   parameter int ADDR_BITS = ADDR_W,
   parameter int NUM_BYTES = DATA_BYTES
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_qualify_n,
   input wire logic chip_sel_n_a,
   input wire logic chip_sel_b,
   input wire logic chip_sel_n_c,
   input wire logic write_sel_n,
   input wire logic advance_or_load,
   input wire logic [NUM_BYTES-1:0] byte_write_n,
   input wire logic [ADDR_BITS-1:0] addr,
   input wire logic out_drive_n,
   input wire logic sleep_req,
   input wire logic mode_strap,
   input wire logic [NUM_BYTES*BYTE_W-1:0] data_i,
   output logic [NUM_BYTES*BYTE_W-1:0] data_o,
   output logic [NUM_BYTES*BYTE_W-1:0] data_oe,
   input wire logic [NUM_BYTES-1:0] parity_io_i,
   output logic [NUM_BYTES-1:0] parity_io_o,
   output logic [NUM_BYTES-1:0] parity_io_oe,
   output logic asleep
);
   localparam int DW = NUM_BYTES * BYTE_W;
   localparam int DEPTH = 1 << ADDR_BITS;

   // ==========================================================
   // input synchronisers for the asynchronous pins
   // ==========================================================
   logic [SLEEP_SYNC_STAGES-1:0] sleep_sync_reg;
   logic [1:0] drive_sync_reg;
   logic sleep_s;
   logic drive_n_s;

   // two flops each; only the last stage is read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sleep_sync_reg <= '0;
         drive_sync_reg <= 2'h3;
      end else begin
         sleep_sync_reg <= {sleep_sync_reg[0], sleep_req};
         drive_sync_reg <= {drive_sync_reg[0], out_drive_n};
      end
   end
   assign sleep_s = sleep_sync_reg[SLEEP_SYNC_STAGES-1];
   assign drive_n_s = drive_sync_reg[1];

   // ==========================================================
   // strap capture after reset release
   // ==========================================================
   logic [1:0] strap_sync_reg;
   logic strap_done_reg;
   logic linear_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         strap_sync_reg <= 2'h3;
         strap_done_reg <= 1'b0;
         linear_reg <= 1'b0;
      end else begin
         strap_sync_reg <= {strap_sync_reg[0], mode_strap};
         strap_done_reg <= 1'b1;
         if (strap_done_reg)
            linear_reg <= (strap_sync_reg[1] == MODE_LINEAR);
      end
   end

   // ==========================================================
   // command decode
   // ==========================================================
   port_ctrl_t ctrl;
   logic qual;
   logic selected;
   logic load_cmd;
   logic adv_cmd;

   assign ctrl = '{chip_sel_n_a, chip_sel_b, chip_sel_n_c,
                   write_sel_n, advance_or_load, byte_write_n};
   assign qual = !clk_qualify_n && !sleep_s;
   assign selected = !ctrl.chip_sel_n_a && ctrl.chip_sel_b
                     && !ctrl.chip_sel_n_c;
   assign load_cmd = qual && !ctrl.advance_or_load;
   assign adv_cmd = qual && ctrl.advance_or_load;

   // ==========================================================
   // state, address and write control registers
   // ==========================================================
   port_state_t state_reg;
   port_state_t state_next;
   logic [ADDR_BITS-3:0] upper_reg;
   logic first_reg;
   logic first_next;
   logic [1:0] burst_addr;
   logic [ADDR_BITS-1:0] acc_addr;

   burst_addr_gen u_burst (
      .mclk(mclk),
      .rstn(rstn),
      .load(load_cmd && selected),
      .advance(adv_cmd && state_reg != ST_DESEL),
      .seed(addr[1:0]),
      .linear_mode(linear_reg),
      .burst_addr(burst_addr)
   );

   assign acc_addr = {upper_reg, burst_addr};

   // next state: load picks read/write/deselect, advance keeps type
   always_comb begin
      state_next = state_reg;
      first_next = 1'b0;
      if (sleep_s)
         state_next = ST_SLEEP;
      else if (state_reg == ST_SLEEP)
         state_next = ST_DESEL;
      else if (load_cmd) begin
         if (!selected)
            state_next = ST_DESEL;
         else if (!ctrl.write_sel_n)
            state_next = ST_WRITE;
         else
            state_next = ST_READ;
         first_next = selected && (state_reg == ST_DESEL);
      end
   end

   // held when unqualified: clk_qualify_n high does not deselect
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_DESEL;
         upper_reg <= '0;
         first_reg <= 1'b0;
      end else if (qual || sleep_s || state_reg == ST_SLEEP) begin
         state_reg <= state_next;
         first_reg <= first_next;
         if (load_cmd && selected)
            upper_reg <= addr[ADDR_BITS-1:2];
      end
   end

   // ==========================================================
   // storage array, byte-wise write and flow-through read
   // ==========================================================
   logic [DW-1:0] mem [DEPTH];
   logic [NUM_BYTES-1:0] par_mem [DEPTH];
   logic [DW-1:0] din_reg;
   logic [NUM_BYTES-1:0] pin_reg;
   logic wr_commit;

   // data portion of a write lands on the next qualified edge
   assign wr_commit = qual && state_reg == ST_WRITE;

   // input data register on every qualified edge the pins are inputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         din_reg <= '0;
         pin_reg <= '0;
      end else if (qual && !(|data_oe)) begin
         din_reg <= data_i;
         pin_reg <= parity_io_i;
      end
   end

   // per-byte writes, byte enables taken at the data edge
   for (genvar b = 0; b < NUM_BYTES; b++) begin : g_byte
      always_ff @(posedge mclk) begin
         if (wr_commit && !ctrl.byte_write_n[b]) begin
            mem[acc_addr][b*BYTE_W +: BYTE_W] <= data_i[b*BYTE_W +: BYTE_W];
            par_mem[acc_addr][b] <= parity_io_i[b];
         end
      end
   end

   // flow-through: array word of the address latched at the last edge
   assign data_o = mem[acc_addr];
   assign parity_io_o = par_mem[acc_addr];

   // ==========================================================
   // output enable masking
   // ==========================================================
   logic drive_ok;

   // pins drive only in a read, not first cycle after deselect, drive enable low
   assign drive_ok = (state_reg == ST_READ) && !first_reg
                     && !drive_n_s;
   assign data_oe = {DW{drive_ok}};
   assign parity_io_oe = {NUM_BYTES{drive_ok}};
   assign asleep = (state_reg == ST_SLEEP);
endmodule : sync_sram_port_control
`default_nettype wire

/* tb/pin_bus_model.sv */
// partner: shared data and parity wires of the memory bus
`timescale 1ns/1ns
`default_nettype none
module pin_bus_model (
   input wire logic mclk,
   input wire logic [35:0] ctrl_val,
   input wire logic ctrl_en,
   input wire logic [35:0] dev_val,
   input wire logic [35:0] dev_oe,
   output logic [35:0] pin,
   output logic clash
);
   logic [35:0] last_reg;
   // a released wire shows the inverse of its last level
   assign pin = ctrl_en ? ctrl_val : dev_oe[0] ? dev_val : ~last_reg;
   assign clash = ctrl_en && |dev_oe;
   always_ff @(posedge mclk) last_reg <= pin;
endmodule : pin_bus_model
`default_nettype wire

/* tb/sram_port_chk.sv */
// checker: pin assertions for the sram port control
`timescale 1ns/1ns
`default_nettype none
module sram_port_chk
   import sram_port_pkg::*;
#(parameter int NUM_BYTES = DATA_BYTES)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_qualify_n,
   input wire logic chip_sel_n_a,
   input wire logic chip_sel_b,
   input wire logic chip_sel_n_c,
   input wire logic write_sel_n,
   input wire logic advance_or_load,
   input wire logic out_drive_n,
   input wire logic sleep_req,
   input wire logic [NUM_BYTES*BYTE_W-1:0] data_o,
   input wire logic [NUM_BYTES*BYTE_W-1:0] data_oe,
   input wire logic [NUM_BYTES-1:0] parity_io_oe,
   input wire logic asleep
);
   // qualified load, selected read and drive-allowed terms
   wire logic sel = !chip_sel_n_a && chip_sel_b && !chip_sel_n_c;
   wire logic ld = !clk_qualify_n && !advance_or_load;
   wire logic rd = ld && sel && write_sel_n;
   wire logic drv = !out_drive_n && !sleep_req && !asleep;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ==========
   // assertions
   desel_off_a: assert property (ld && !sel |=> !data_oe)
      else $error("outputs on after deselect");
   write_off_a: assert property (ld && sel && !write_sel_n |=> !data_oe)
      else $error("outputs on in write data cycle");
   first_masked_a: assert property (ld && !sel ##1 rd |=> !data_oe)
      else $error("outputs on in first read after deselect");
   drive_off_a: assert property (out_drive_n [*4] |-> !data_oe)
      else $error("outputs on with drive disabled");
   read_on_a: assert property (drv ##1 drv && rd ##1 drv && rd
      |=> data_oe[0] && parity_io_oe[0])
      else $error("outputs off in second read");
   par_same_a: assert property (parity_io_oe == {NUM_BYTES{data_oe[0]}}
      && data_oe == {NUM_BYTES*BYTE_W{data_oe[0]}})
      else $error("parity enable differs from data");
   sleep_off_a: assert property (asleep |-> !data_oe && !parity_io_oe)
      else $error("outputs on while asleep");
   sleep_in_a: assert property ((sleep_req && !clk_qualify_n) [*5] |-> asleep)
      else $error("sleep not entered");
   stall_hold_a: assert property ((clk_qualify_n && drv) [*3]
      |=> $stable(data_o) && $stable(data_oe))
      else $error("outputs moved during stall");
endmodule : sram_port_chk
bind sync_sram_port_control sram_port_chk #(.NUM_BYTES(NUM_BYTES)) chk (
   .mclk, .rstn, .clk_qualify_n, .chip_sel_n_a, .chip_sel_b, .chip_sel_n_c,
   .write_sel_n, .advance_or_load, .out_drive_n, .sleep_req, .data_o,
   .data_oe, .parity_io_oe, .asleep);
`default_nettype wire

/* tb/tb.sv */
// testbench: bursts, byte writes, stalls, sleep and drive enable
`timescale 1ns/1ns
`default_nettype none
module tb
   import sram_port_pkg::*;
;
   logic mclk = 0, rstn = 0, clk_qualify_n = 1, out_drive_n = 0;
   logic sleep_req = 0, mode_strap = 0, drv = 0, prevq = 1, quiet = 0;
   logic wpend, prevrd, bwr, asleep, clash;
   logic [1:0] cnt;
   logic [3:0] pbe, parity_io_o, parity_io_oe;
   logic [9:0] addr = '0, base, pa;
   logic [31:0] data_o, data_oe, rnd = 32'h8c240c6c;
   logic [35:0] cval = '0, pin, mem [1024];
   logic [36:0] nq [$];
   port_ctrl_t ctl = '1;
   int fails = 0, comparisons = 0;
   // ==========
   // design and bus
   sync_sram_port_control uut (.mclk, .rstn, .clk_qualify_n,
      .chip_sel_n_a(ctl.chip_sel_n_a), .chip_sel_b(ctl.chip_sel_b),
      .chip_sel_n_c(ctl.chip_sel_n_c), .write_sel_n(ctl.write_sel_n),
      .advance_or_load(ctl.advance_or_load), .byte_write_n(ctl.byte_write_n),
      .addr, .out_drive_n, .sleep_req, .mode_strap, .data_i(pin[31:0]),
      .data_o, .data_oe, .parity_io_i(pin[35:32]), .parity_io_o,
      .parity_io_oe, .asleep);
   pin_bus_model bus (.mclk, .ctrl_val(cval), .ctrl_en(drv),
      .dev_val({parity_io_o, data_o}), .dev_oe({parity_io_oe, data_oe}),
      .pin, .clash);
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) prevq <= clk_qualify_n;
   // ==========
   // tasks
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   task automatic check(input string what, input logic [35:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   // one access, maybe after a stall; write data goes one edge late
   task automatic op(input int k, input logic [9:0] a, input logic [3:0] b);
      logic [2:0] cs;
      logic [35:0] w;
      rnd = next_rand(rnd);
      w = {rnd[3:0], ~rnd};
      cs = (k == 3 || rnd[14:12] != 3'h2) ? rnd[14:12] : 3'h7;
      if (k == 1 || k == 2) cs = 3'h2;
      repeat (rnd[9:8] == 0 ? rnd[11:10] : 0) begin
         @(posedge mclk);
         {clk_qualify_n, ctl, drv, cval} <= {1'h1, rnd[8:0], wpend, w};
      end
      @(posedge mclk);
      clk_qualify_n <= 0;
      ctl <= {cs, k == 3 ? rnd[15] : k != 2, k == 3, pbe};
      {addr, drv, cval} <= {k == 3 ? rnd[25:16] : a, wpend, w};
      for (int i = 0; i < 4; i++)
         if (wpend && !pbe[i]) begin
            mem[pa][8*i+:8] = w[8*i+:8];
            mem[pa][32+i] = w[32+i];
         end
      if (k == 3) cnt++;
      if (k == 1 || k == 2) {base, cnt, bwr} = {a, 2'h0, k == 2};
      if (k == 3)
         a = {base[9:2], mode_strap ? base[1:0] ^ cnt : base[1:0] + cnt};
      if (!quiet && (k == 1 || k == 3 && !bwr)) nq.push_back({!prevrd, mem[a]});
      else if (prevrd && nq.size() > 0) nq[$][36] = 1'h1;
      prevrd = k == 1 || k == 3 && !bwr;
      wpend = k == 2 || k == 3 && bwr;
      {pa, pbe} = {a, b};
   endtask : op
   // watcher: one note per qualified edge that shows read data
   always @(negedge mclk) begin
      if (rstn && !prevq && data_oe[0] === 1'h1) begin
         while (nq.size() > 0 && nq[0][36]
            && nq[0][35:0] !== {parity_io_o, data_o}) void'(nq.pop_front());
         if (nq.size() == 0) check("spare read", '1, '0);
         else begin
            check("read data", {parity_io_o, data_o}, nq[0][35:0]);
            void'(nq.pop_front());
         end
      end
      if (clash !== 1'h0) check("bus clash", '1, '0);
   end
   // main sequence: both burst orders, each after its own reset
   initial begin
      logic [9:0] a;
      for (int m = 0; m < 2; m++) begin
         rstn <= 0;
         mode_strap <= m[0];
         wpend = 0;
         prevrd = 0;
         repeat (12) @(posedge mclk);
         rstn <= 1;
         repeat (3) @(posedge mclk);
         op(0, 0, 0);
         for (int j = 0; j < 12; j++) begin
            quiet = j == 7;
            out_drive_n <= j == 7;
            rnd = next_rand(rnd);
            a = rnd[9:0];
            op(2, a, 0);
            repeat (3) op(3, 0, 0);
            op(2, a, rnd[13:10]);
            if (j == 5) begin
               op(0, 0, 0);
               sleep_req <= 1;
               repeat (6) op(0, 0, 0);
               @(negedge mclk) check("asleep", {35'h0, asleep}, 36'h1);
               @(posedge mclk) sleep_req <= 0;
               repeat (6) op(0, 0, 0);
            end
            op(1, a, 0);
            repeat (3) op(3, 0, 0);
            repeat (2) op(1, a, 0);
            if (j[0]) op(0, 0, 0);
         end
         repeat (2) @(negedge mclk);
         foreach (nq[i]) if (!nq[i][36]) check("lost read", '0, '1);
         nq.delete();
      end
      final_report();
   end
endmodule : tb
`default_nettype wire
